/* File: pkg/cal_io_pkg.sv */
/*
 * Constants, register map and types for the rear-panel discrete I/O block.
 * Assumes a 125 MHz clock and a simple strobe register port.
 */
package cal_io_pkg;
    // -----------------------------------------------------------------
    // Register map.
    // -----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL    = 4'h0;
    localparam logic [3:0] ADDR_ALCFG   = 4'h1;
    localparam logic [3:0] ADDR_THR1    = 4'h2;
    localparam logic [3:0] ADDR_THR2    = 4'h3;
    localparam logic [3:0] ADDR_CONC    = 4'h4;
    localparam logic [3:0] ADDR_STATUS  = 4'h5;
    localparam logic [3:0] ADDR_IRQST   = 4'h6;
    localparam logic [3:0] ADDR_IRQMSK  = 4'h7;
    localparam logic [3:0] ADDR_CALLEN  = 4'h8;
    // CTRL fields.
    localparam int CTRL_RANGE_LSB = 0;  // Two bits: 1..3.
    localparam int CTRL_DIGMODE   = 2;
    localparam int CTRL_CALDONE   = 3;  // Write 1: current calibration done.
    // Alarm config fields per alarm (4 bits each at 4*i).
    localparam int AL_EN = 0;
    localparam int AL_HIGH = 1;
    localparam int AL_FAILSAFE = 2;
    // Interrupt event bits.
    localparam int EV_CALSTART = 0;
    localparam int EV_CALEND   = 1;
    localparam int EV_ALARM1   = 2;
    localparam int EV_ALARM2   = 3;
    localparam int EV_SYSALARM = 4;
    localparam int EV_W        = 5;
    // Reset values.
    localparam logic [1:0]  RANGE_RST  = 2'h1;
    localparam logic [7:0]  ALCFG_RST  = 8'h00;
    localparam logic [15:0] CALLEN_RST = 16'h0100;
    localparam logic [15:0] THR_RST    = 16'hFFFF;
    // Output codes: voltage code full scale = 1 V, current code in uA.
    localparam logic [15:0] VCODE_FS   = 16'h03E8;  // Millivolts.
    localparam logic [15:0] I_ZERO_UA  = 16'h0FA0;  // 4000 uA.
    localparam logic [15:0] I_SPAN_UA  = 16'h3E80;  // 16000 uA.
    localparam logic [15:0] RID_V1     = 16'h00C8;  // 200 mV.
    localparam logic [15:0] RID_V2     = 16'h01F4;  // 500 mV.
    localparam logic [15:0] RID_V3     = 16'h0320;  // 800 mV.
    localparam logic [15:0] RID_I1     = 16'h1A90;  // 6800 uA.
    localparam logic [15:0] RID_I2     = 16'h2EE0;  // 12000 uA.
    localparam logic [15:0] RID_I3     = 16'h41A0;  // 16800 uA.
    // Calibration step time unit: 1 ms at 125 MHz.
    localparam int CLK_MHZ      = 125;
    localparam int TICK_US      = 1000;
    localparam int TICK_CYCLES  = TICK_US * CLK_MHZ;

    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_ZERO = 2'b01,
        CAL_SPAN = 2'b10
    } cal_state_t;
endpackage : cal_io_pkg

/* File: rtl/threshold_alarm.sv */
/*
 * One threshold alarm relay driver.
 * Assumes concentration and threshold share scaling and the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module threshold_alarm (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [15:0] conc,
    input  wire logic [15:0] thresh,
    input  wire logic        enable,
    input  wire logic        highType,
    input  wire logic        failsafe,
    output logic             alarm,
    output logic             coil
);
    logic trip;

    // High alarm trips above threshold, low alarm below it.
    always_comb begin
        if (!enable) begin
            trip = 1'b0;
        end else if (highType) begin
            trip = conc > thresh;
        end else begin
            trip = conc < thresh;
        end
    end

    // Relay coil follows the failsafe sense chosen per alarm.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            alarm <= 1'b0;
            coil  <= 1'b0;
        end else begin
            alarm <= trip;
            coil  <= failsafe ? !trip : trip;
        end
    end
endmodule : threshold_alarm
`default_nettype wire

/* File: rtl/remote_cal_alarm_range_io.sv */
/*
 * Rear-panel discrete I/O: remote calibration handshake, alarm relays,
 * range ID relays and analog output codes.
 * Assumes remote inputs and supply fault arrive asynchronously from pins;
 * the calibration engine reports completion through a register write or
 * the internal step timer.
 */
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module remote_cal_alarm_range_io (
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Register port.
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [15:0]      regRdata,
    // Pins.
    input  wire logic        remoteZero,
    input  wire logic        remoteSpan,
    input  wire logic        supplyFault,
    input  wire logic        standbyOff,
    output logic             calContact,
    output logic             zeroValve,
    output logic             spanValve,
    output logic             alarm1Coil,
    output logic             alarm2Coil,
    output logic             sysAlarmCoil,
    output logic [2:0]       rangeRelay,
    output logic [1:0]       digRangeSel,
    output logic [15:0]      concVoltCode,
    output logic [15:0]      concCurrCode,
    output logic [15:0]      rangeVoltCode,
    output logic [15:0]      rangeCurrCode,
    output logic             irq
);
    // -----------------------------------------------------------------
    // Input synchronisers.
    // -----------------------------------------------------------------
    logic [3:0] syncA_q;
    logic [3:0] syncB_q;

    // Two flops per pin; only syncB_q is read by logic.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            syncA_q <= 4'h0;
            syncB_q <= 4'h0;
        end else begin
            syncA_q <= {standbyOff, supplyFault, remoteSpan, remoteZero};
            syncB_q <= syncA_q;
        end
    end

    logic zeroIn;
    logic spanIn;
    logic faultIn;
    logic standbyIn;
    assign zeroIn    = syncB_q[0];
    assign spanIn    = syncB_q[1];
    assign faultIn   = syncB_q[2];
    assign standbyIn = syncB_q[3];

    // -----------------------------------------------------------------
    // Configuration registers.
    // -----------------------------------------------------------------
    logic [1:0]  range_q;
    logic        digMode_q;
    logic [7:0]  alCfg_q;
    logic [15:0] thr1_q;
    logic [15:0] thr2_q;
    logic [15:0] conc_q;
    logic [15:0] calLen_q;
    localparam int EV_W_C = cal_io_pkg::EV_W;
    logic [EV_W_C-1:0] irqMask_q;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = regWr && (a == r);
    endfunction : hit

    // Software-written settings; range code 0 is refused and kept.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            range_q   <= cal_io_pkg::RANGE_RST;
            digMode_q <= 1'b0;
            alCfg_q   <= cal_io_pkg::ALCFG_RST;
            thr1_q    <= cal_io_pkg::THR_RST;
            thr2_q    <= cal_io_pkg::THR_RST;
            conc_q    <= 16'h0000;
            calLen_q  <= cal_io_pkg::CALLEN_RST;
            irqMask_q <= '0;
        end else begin
            if (hit(regAddr, cal_io_pkg::ADDR_CTRL)) begin
                if (regWdata[cal_io_pkg::CTRL_RANGE_LSB +: 2] != 2'h0) begin
                    range_q <= regWdata[cal_io_pkg::CTRL_RANGE_LSB +: 2];
                end
                digMode_q <= regWdata[cal_io_pkg::CTRL_DIGMODE];
            end
            if (hit(regAddr, cal_io_pkg::ADDR_ALCFG)) begin
                alCfg_q <= regWdata[7:0];
            end
            if (hit(regAddr, cal_io_pkg::ADDR_THR1)) begin
                thr1_q <= regWdata;
            end
            if (hit(regAddr, cal_io_pkg::ADDR_THR2)) begin
                thr2_q <= regWdata;
            end
            if (hit(regAddr, cal_io_pkg::ADDR_CONC)) begin
                conc_q <= regWdata;
            end
            if (hit(regAddr, cal_io_pkg::ADDR_CALLEN)) begin
                calLen_q <= regWdata;
            end
            if (hit(regAddr, cal_io_pkg::ADDR_IRQMSK)) begin
                irqMask_q <= regWdata[EV_W_C-1:0];
            end
        end
    end

    // -----------------------------------------------------------------
    // Calibration sequencer.
    // -----------------------------------------------------------------
    cal_io_pkg::cal_state_t calState_q;
    logic [16:0] tickCnt_q;
    logic        tick;
    logic [15:0] stepCnt_q;
    logic        calDone;
    logic        calStart;
    logic        calEnd;
    logic        swDone;

    assign swDone = hit(regAddr, cal_io_pkg::ADDR_CTRL)
                    && regWdata[cal_io_pkg::CTRL_CALDONE];

    // Millisecond enable for the calibration step timer.
    always_ff @(posedge clk) begin
        if (!rst_b || tick) begin
            tickCnt_q <= 17'h00000;
        end else begin
            tickCnt_q <= tickCnt_q + 17'h00001;
        end
    end
    assign tick = (tickCnt_q == 17'(cal_io_pkg::TICK_CYCLES - 1));

    // A step ends when its timer runs out or software says it is done.
    assign calDone = (calState_q != cal_io_pkg::CAL_IDLE)
                     && (swDone || (tick && stepCnt_q == 16'h0001));

    // In digital range mode the inputs never start a calibration.
    // Inputs are polled only while idle, so a request dropped before the busy step ends is lost.
    assign calStart = (calState_q == cal_io_pkg::CAL_IDLE) && !digMode_q
                      && (zeroIn || spanIn);
    assign calEnd = calDone;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            calState_q <= cal_io_pkg::CAL_IDLE;
            stepCnt_q  <= 16'h0000;
        end else begin
            case (calState_q)
                cal_io_pkg::CAL_IDLE: begin
                    stepCnt_q <= calLen_q;
                    if (calStart && zeroIn) begin
                        calState_q <= cal_io_pkg::CAL_ZERO;
                    end else if (calStart) begin
                        calState_q <= cal_io_pkg::CAL_SPAN;
                    end
                end
                cal_io_pkg::CAL_ZERO,
                cal_io_pkg::CAL_SPAN: begin
                    if (calDone) begin
                        // Back to idle; a held request re-enters next cycle.
                        calState_q <= cal_io_pkg::CAL_IDLE;
                    end else if (tick) begin
                        stepCnt_q <= stepCnt_q - 16'h0001;
                    end
                end
                default: begin
                    calState_q <= cal_io_pkg::CAL_IDLE;
                end
            endcase
        end
    end

    // Busy contact and gas valves are registered from the state and gated off by calDone.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            calContact <= 1'b0;
            zeroValve  <= 1'b0;
            spanValve  <= 1'b0;
        end else begin
            calContact <= (calState_q != cal_io_pkg::CAL_IDLE)
                          && !calDone;
            zeroValve  <= (calState_q == cal_io_pkg::CAL_ZERO) && !calDone;
            spanValve  <= (calState_q == cal_io_pkg::CAL_SPAN) && !calDone;
        end
    end

    // Range select in digital mode is the raw pair of inputs.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            digRangeSel <= 2'h0;
        end else begin
            digRangeSel <= digMode_q ? {spanIn, zeroIn} : 2'h0;
        end
    end

    // -----------------------------------------------------------------
    // Alarms.
    // -----------------------------------------------------------------
    logic [1:0] thAlarm;
    logic [1:0] thCoil;
    logic [15:0] thrArr [2];
    assign thrArr[0] = thr1_q;
    assign thrArr[1] = thr2_q;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_alarm
            threshold_alarm u_alarm (
                .clk      (clk),
                .rst_b    (rst_b),
                .conc     (conc_q),
                .thresh   (thrArr[gi]),
                .enable   (alCfg_q[4*gi + cal_io_pkg::AL_EN]),
                .highType (alCfg_q[4*gi + cal_io_pkg::AL_HIGH]),
                .failsafe (alCfg_q[4*gi + cal_io_pkg::AL_FAILSAFE]),
                .alarm    (thAlarm[gi]),
                .coil     (thCoil[gi])
            );
        end
    endgenerate
    assign alarm1Coil = thCoil[0];
    assign alarm2Coil = thCoil[1];

    // System alarm latches; only standby power removal clears it.
    // Ordinary reset does not clear the latch to match panel behaviour.
    logic sysLatch_q;
    always_ff @(posedge clk) begin
        if (faultIn) begin
            sysLatch_q <= 1'b1;
        end else if (standbyIn) begin
            sysLatch_q <= 1'b0;
        end
    end

    // Failsafe coil: energized only while healthy.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sysAlarmCoil <= 1'b0;
        end else begin
            sysAlarmCoil <= !sysLatch_q && !standbyIn;
        end
    end

    // -----------------------------------------------------------------
    // Range ID and analog codes.
    // -----------------------------------------------------------------
    logic [31:0] vProd;
    logic [31:0] iProd;
    assign vProd = 32'(conc_q) * 32'(cal_io_pkg::VCODE_FS) + 32'h00008000;
    assign iProd = 32'(conc_q) * 32'(cal_io_pkg::I_SPAN_UA) + 32'h00008000;

    // Concentration is a fraction of full scale, 16'hFFFF being 100 %.
    // Half a step is added so that 16'hFFFF rounds to the full-scale code.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rangeRelay    <= 3'h0;
            concVoltCode  <= 16'h0000;
            concCurrCode  <= cal_io_pkg::I_ZERO_UA;
            rangeVoltCode <= 16'h0000;
            rangeCurrCode <= cal_io_pkg::I_ZERO_UA;
        end else begin
            concVoltCode <= vProd[31:16];
            concCurrCode <= cal_io_pkg::I_ZERO_UA + iProd[31:16];
            case (range_q)
                2'h1: begin
                    rangeRelay    <= 3'b001;
                    rangeVoltCode <= cal_io_pkg::RID_V1;
                    rangeCurrCode <= cal_io_pkg::RID_I1;
                end
                2'h2: begin
                    rangeRelay    <= 3'b010;
                    rangeVoltCode <= cal_io_pkg::RID_V2;
                    rangeCurrCode <= cal_io_pkg::RID_I2;
                end
                default: begin
                    rangeRelay    <= 3'b100;
                    rangeVoltCode <= cal_io_pkg::RID_V3;
                    rangeCurrCode <= cal_io_pkg::RID_I3;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // Interrupts and read-back.
    // -----------------------------------------------------------------
    logic [EV_W_C-1:0] irqSt_q;
    logic [EV_W_C-1:0] events;
    logic [1:0]        thPrev_q;
    logic              sysPrev_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            thPrev_q  <= 2'h0;
            sysPrev_q <= sysLatch_q;  // A held latch is no new event.
        end else begin
            thPrev_q  <= thAlarm;
            sysPrev_q <= sysLatch_q;
        end
    end

    assign events = {sysLatch_q && !sysPrev_q, thAlarm & ~thPrev_q,
                     calEnd, calStart};

    // Set beats a write-one clear in the same cycle.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            irqSt_q <= '0;
        end else if (hit(regAddr, cal_io_pkg::ADDR_IRQST)) begin
            irqSt_q <= (irqSt_q & ~regWdata[EV_W_C-1:0]) | events;
        end else begin
            irqSt_q <= irqSt_q | events;
        end
    end
    assign irq = |(irqSt_q & irqMask_q);

    // Read data valid the cycle after the read strobe; unmapped reads 0.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regRdata <= 16'h0000;
        end else if (regRd) begin
            case (regAddr)
                cal_io_pkg::ADDR_CTRL:   regRdata <= {13'h0000, digMode_q, range_q};
                cal_io_pkg::ADDR_ALCFG:  regRdata <= {8'h00, alCfg_q};
                cal_io_pkg::ADDR_THR1:   regRdata <= thr1_q;
                cal_io_pkg::ADDR_THR2:   regRdata <= thr2_q;
                cal_io_pkg::ADDR_CONC:   regRdata <= conc_q;
                cal_io_pkg::ADDR_STATUS: regRdata <= {9'h000, sysLatch_q,
                                             thAlarm, calContact, calState_q,
                                             digMode_q};
                cal_io_pkg::ADDR_IRQST:  regRdata <= 16'(irqSt_q);
                cal_io_pkg::ADDR_IRQMSK: regRdata <= 16'(irqMask_q);
                cal_io_pkg::ADDR_CALLEN: regRdata <= calLen_q;
                default:                 regRdata <= 16'h0000;
            endcase
        end else begin
            regRdata <= 16'h0000;
        end
    end
endmodule : remote_cal_alarm_range_io
`default_nettype wire

/* File: tb/cal_io_monitor.sv */
/*
 * Port checker for the rear-panel calibration, alarm and range block.
 * Assumes it is bound to the block's top module; single clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module cal_io_monitor (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        standbyOff,
    input wire logic        supplyFault,
    input wire logic        calContact,
    input wire logic        zeroValve,
    input wire logic        spanValve,
    input wire logic        sysAlarmCoil,
    input wire logic [2:0]  rangeRelay,
    input wire logic [1:0]  digRangeSel,
    input wire logic [15:0] rangeVoltCode,
    input wire logic [15:0] rangeCurrCode
);
    logic [2:0] quietCnt_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Cycles since standby last removed power; the latch may only clear
    // after such an event has passed the input synchroniser.
    always_ff @(posedge clk) begin
        if (!rst_b || standbyOff) begin
            quietCnt_q <= 3'h0;
        end else if (quietCnt_q != 3'h7) begin
            quietCnt_q <= quietCnt_q + 3'h1;
        end
    end

    a_contact_valves: assert property (
        calContact == (zeroValve || spanValve))
        else $error("busy contact disagrees with valves");
    a_valves_apart: assert property (
        !(zeroValve && spanValve))
        else $error("zero and span valves open together");
    a_busy_ignores: assert property (
        $rose(spanValve) |-> !$past(calContact))
        else $error("span began inside a running calibration");
    a_range_onehot: assert property (
        $past(rst_b) |-> $onehot(rangeRelay))
        else $error("range relays not one-hot");
    a_range_codes: assert property (
        rangeRelay == 3'b100 && $stable(rangeRelay) |->
        rangeVoltCode == cal_io_pkg::RID_V3 &&
        rangeCurrCode == cal_io_pkg::RID_I3)
        else $error("range three codes wrong");
    a_digital_nocal: assert property (
        digRangeSel != 2'b00 |-> !calContact)
        else $error("calibration ran in digital range mode");
    a_sys_trip: assert property (
        supplyFault [*5] |-> !sysAlarmCoil)
        else $error("system alarm did not trip");
    a_sys_latch: assert property (
        quietCnt_q == 3'h7 && !sysAlarmCoil |=> !sysAlarmCoil)
        else $error("system alarm cleared without standby");
endmodule : cal_io_monitor

bind remote_cal_alarm_range_io cal_io_monitor i_cal_io_monitor (
    .clk, .rst_b, .standbyOff, .supplyFault, .calContact, .zeroValve,
    .spanValve, .sysAlarmCoil, .rangeRelay, .digRangeSel, .rangeVoltCode,
    .rangeCurrCode);
`default_nettype wire

/* File: tb/cal_controller_model.sv */
/*
 * Model of the process controller that watches the busy contact.
 * Assumes the bench commands each request as a level.
 */
`timescale 1ns/1ps
`default_nettype none
module cal_controller_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic calContact,
    input wire logic reqZero,
    input wire logic reqSpan,
    input wire logic breakRules,
    output logic     remoteZero,
    output logic     remoteSpan
);
    // A request goes out only while the contact is open and is dropped
    // once it closes; breakRules keeps it up to provoke the device.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            remoteZero <= 1'b0;
            remoteSpan <= 1'b0;
        end else begin
            remoteZero <= reqZero && (breakRules || !calContact);
            remoteSpan <= reqSpan && (breakRules || !calContact);
        end
    end
endmodule : cal_controller_model
`default_nettype wire

/* File: tb/tb.sv */
/*
 * Self-checking bench for the rear-panel I/O block.
 * Assumes the register port and the controller model above.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, rst_b, regWr, regRd, supplyFault, standbyOff;
    logic        remoteZero, remoteSpan, calContact, zeroValve, spanValve;
    logic        alarm1Coil, alarm2Coil, sysAlarmCoil, irq;
    logic        reqZero, reqSpan, breakRules;
    logic [3:0]  regAddr;
    logic [2:0]  rangeRelay, a1, a2;
    logic [1:0]  digRangeSel;
    logic [15:0] regWdata, regRdata, concVoltCode, concCurrCode, cv;
    logic [15:0] rangeVoltCode, rangeCurrCode;
    logic [15:0] rv [3] = '{cal_io_pkg::RID_V1, cal_io_pkg::RID_V2,
                            cal_io_pkg::RID_V3};
    logic [15:0] ri [3] = '{cal_io_pkg::RID_I1, cal_io_pkg::RID_I2,
                            cal_io_pkg::RID_I3};
    int          errCount, checksDone, cycles;

    remote_cal_alarm_range_io i_remote_cal_alarm_range_io (.clk, .rst_b,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .remoteZero,
        .remoteSpan, .supplyFault, .standbyOff, .calContact, .zeroValve,
        .spanValve, .alarm1Coil, .alarm2Coil, .sysAlarmCoil, .rangeRelay,
        .digRangeSel, .concVoltCode, .concCurrCode, .rangeVoltCode,
        .rangeCurrCode, .irq);
    cal_controller_model i_cal_controller_model (.clk, .rst_b, .calContact,
        .reqZero, .reqSpan, .breakRules, .remoteZero, .remoteSpan);

    // ------------------------------------------------------------------
    // Clock, hang guard and helpers.
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // The tests need a few hundred cycles; this ceiling catches a hang.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errCount++;
            final_report();
        end
    end

    task chk(input logic [15:0] got, input logic [15:0] exp);
        checksDone++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            errCount++;
        end
    endtask : chk

    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask : wr

    task rdc(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask : rdc

    // Bounded wait for the busy contact, then a check of its level.
    task waitc(input logic e);
        int n;
        n = 0;
        while (calContact !== e && n < 60) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk(16'(calContact), 16'(e));
    endtask : waitc

    function automatic logic coilx(logic [2:0] c, logic [15:0] v);
        logic t;
        t = c[0] && (c[1] ? v > 16'h1000 : v < 16'h1000);
        return c[2] ? !t : t;
    endfunction : coilx

    task final_report();
        $display("checks %0d mismatches %0d", checksDone, errCount);
        if (errCount == 0 && checksDone > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ------------------------------------------------------------------
    // Test sequence.
    // ------------------------------------------------------------------
    initial begin
        {regWr, regRd, supplyFault, reqZero, reqSpan, breakRules} = '0;
        regAddr    = 4'h0;
        regWdata   = 16'h0000;
        rst_b      = 1'b0;
        standbyOff = 1'b1;
        errCount   = 0;
        checksDone = 0;
        cycles     = 0;
        repeat (2) @(posedge clk);
        rst_b      <= 1'b1;
        repeat (4) @(posedge clk);
        standbyOff <= 1'b0;
        repeat (8) @(posedge clk);
        chk(16'(sysAlarmCoil), 16'h0001);
        rdc(cal_io_pkg::ADDR_CALLEN, cal_io_pkg::CALLEN_RST);
        rdc(4'hF, 16'h0000);
        $display("test reset done");
        // A range code of zero is refused and must leave the range alone.
        for (int r = 1; r <= 3; r++) begin
            wr(cal_io_pkg::ADDR_CTRL, 16'(r));
            wr(cal_io_pkg::ADDR_CTRL, 16'h0000);
            repeat (3) @(posedge clk);
            chk(16'(rangeRelay), 16'(1 << (r - 1)));
            chk(rangeVoltCode, rv[r-1]);
            chk(rangeCurrCode, ri[r-1]);
        end
        for (int k = 0; k < 2; k++) begin
            wr(cal_io_pkg::ADDR_CONC, k ? 16'hFFFF : 16'h0000);
            repeat (3) @(posedge clk);
            chk(concVoltCode, k ? cal_io_pkg::VCODE_FS : 16'h0000);
            chk(concCurrCode, cal_io_pkg::I_ZERO_UA +
                (k ? cal_io_pkg::I_SPAN_UA : 16'h0000));
        end
        $display("test outputs done");
        // Alarm two always differs from alarm one in failsafe sense.
        wr(cal_io_pkg::ADDR_THR1, 16'h1000);
        wr(cal_io_pkg::ADDR_THR2, 16'h1000);
        for (int c = 0; c < 16; c++) begin
            a1 = 3'(c >> 1);
            a2 = a1 ^ 3'b100;
            cv = c[0] ? 16'h2000 : 16'h0800;
            wr(cal_io_pkg::ADDR_ALCFG, {9'h000, a2, 1'b0, a1});
            wr(cal_io_pkg::ADDR_CONC, cv);
            repeat (3) @(posedge clk);
            chk(16'(alarm1Coil), 16'(coilx(a1, cv)));
            chk(16'(alarm2Coil), 16'(coilx(a2, cv)));
        end
        wr(cal_io_pkg::ADDR_ALCFG, 16'h0000);
        $display("test alarms done");
        wr(cal_io_pkg::ADDR_IRQST, 16'h001F);
        reqZero <= 1'b1;
        waitc(1'b1);
        chk(16'(zeroValve), 16'h0001);
        reqZero    <= 1'b0;
        breakRules <= 1'b1;
        reqSpan    <= 1'b1;
        repeat (10) @(posedge clk);
        reqSpan    <= 1'b0;
        breakRules <= 1'b0;
        repeat (5) @(posedge clk);
        chk(16'(spanValve), 16'h0000);
        wr(cal_io_pkg::ADDR_CTRL, 16'h0009);
        waitc(1'b0);
        repeat (10) @(posedge clk);
        chk(16'(calContact), 16'h0000);
        breakRules <= 1'b1;
        reqZero    <= 1'b1;
        waitc(1'b1);
        wr(cal_io_pkg::ADDR_CTRL, 16'h0009);
        waitc(1'b0);
        waitc(1'b1);
        chk(16'(zeroValve), 16'h0001);
        reqZero    <= 1'b0;
        breakRules <= 1'b0;
        repeat (5) @(posedge clk);
        wr(cal_io_pkg::ADDR_CTRL, 16'h0009);
        waitc(1'b0);
        reqSpan <= 1'b1;
        waitc(1'b1);
        chk(16'(spanValve), 16'h0001);
        reqSpan <= 1'b0;
        repeat (5) @(posedge clk);
        wr(cal_io_pkg::ADDR_CTRL, 16'h0009);
        waitc(1'b0);
        rdc(cal_io_pkg::ADDR_STATUS, 16'h0000);
        $display("test calibration done");
        rdc(cal_io_pkg::ADDR_IRQST, 16'h0003);
        chk(16'(irq), 16'h0000);
        wr(cal_io_pkg::ADDR_IRQMSK, 16'h0002);
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h0001);
        wr(cal_io_pkg::ADDR_IRQST, 16'h0002);
        @(posedge clk);
        #1;
        chk(16'(irq), 16'h0000);
        $display("test interrupt done");
        wr(cal_io_pkg::ADDR_CTRL, 16'h0005);
        reqZero <= 1'b1;
        repeat (6) @(posedge clk);
        chk(16'(digRangeSel), 16'h0001);
        chk(16'(calContact), 16'h0000);
        reqZero <= 1'b0;
        repeat (5) @(posedge clk);
        wr(cal_io_pkg::ADDR_CTRL, 16'h0001);
        $display("test digital done");
        supplyFault <= 1'b1;
        repeat (8) @(posedge clk);
        supplyFault <= 1'b0;
        repeat (8) @(posedge clk);
        chk(16'(sysAlarmCoil), 16'h0000);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        chk(16'(sysAlarmCoil), 16'h0000);
        standbyOff <= 1'b1;
        repeat (2) @(posedge clk);
        standbyOff <= 1'b0;
        repeat (8) @(posedge clk);
        chk(16'(sysAlarmCoil), 16'h0001);
        $display("test system alarm done");
        final_report();
    end
endmodule : tb
`default_nettype wire
